// ===== design/digital_port_pkg.sv
// Constants for the three-line multimode digital port.
// Assumes a single 200 MHz core clock and a plain strobe register port.
package digital_port_pkg;
  // Port modes
  typedef enum logic [1:0] {
    MODE_FAULT_INHIBIT,
    MODE_DIGITAL_IO,
    MODE_RELAY_LINK
  } port_mode_t;
  // Register offsets (byte addresses)
  localparam logic [7:0] PORT_VALUE_OFS = 8'h00;
  localparam logic [7:0] LINE2_DIR_OFS = 8'h04;
  localparam logic [7:0] OPER_EVENT_OFS = 8'h08;
  localparam logic [7:0] OPER_ENABLE_OFS = 8'h0C;
  localparam logic [7:0] QUES_EVENT_OFS = 8'h10;
  localparam logic [7:0] QUES_ENABLE_OFS = 8'h14;
  localparam logic [7:0] STD_EVENT_OFS = 8'h18;
  localparam logic [7:0] STD_ENABLE_OFS = 8'h1C;
  localparam logic [7:0] PROT_CLEAR_OFS = 8'h20;
  localparam logic [7:0] RELAY_CMD_OFS = 8'h24;
  localparam logic [7:0] CTRL_STATUS_OFS = 8'h28;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h2C;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h30;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h34;
  // Field positions
  localparam int VALUE_LINE0_BIT = 0;
  localparam int VALUE_LINE1_BIT = 1;
  localparam int VALUE_LINE2_BIT = 2;
  localparam int QUES_SHUTDOWN_BIT = 9;
  localparam int IRQ_SHUTDOWN_BIT = 0;
  localparam int IRQ_RELAY_ERR_BIT = 1;
  localparam int IRQ_RELAY_DONE_BIT = 2;
  localparam int IRQ_FAULT_BIT = 3;
  // Widths and reset values
  localparam int STATUS_W = 16;
  localparam int IRQ_W = 4;
  localparam logic [2:0] PORT_VALUE_RST = 3'h7;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  // Relay serial bit time
  localparam int CLK_MHZ = 200;
  localparam int RELAY_BIT_NS = 10_000;
  localparam int RELAY_BIT_CYC = (RELAY_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RELAY_BITS = 8;
endpackage

// ===== design/multimode_digital_port.sv
// Multimode digital port: fault/inhibit, digital I/O and relay link.
// Assumes inputs synchronous to core_clk; mode strap stable after reset.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module multimode_digital_port #(
  parameter int RELAY_BITS = digital_port_pkg::RELAY_BITS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [31:0] regRdData,
  input wire logic strapDigitalIo,
  input wire logic strapRelayLink,
  input wire logic analogProgramming,
  input wire logic [15:0] operCondition,
  input wire logic [15:0] quesCondition,
  input wire logic [15:0] stdCondition,
  input wire logic frontPanelClear,
  input wire logic line0In,
  output logic line0Out,
  output logic line0Oe,
  output logic line1Out,
  output logic line1Oe,
  input wire logic line2In,
  output logic line2Out,
  output logic line2Oe,
  output logic outputEnable,
  output logic protIndicator,
  output logic serviceRequest,
  output logic irq
);
  localparam int SW = digital_port_pkg::STATUS_W;
  localparam int IW = digital_port_pkg::IRQ_W;
  // Register map in brief:
  // 00 port value, 04 line 2 direction
  // 08..1C event and enable pairs
  // 20 protection clear, any write
  // 24 relay command and readback
  // 28 control and status, read clears error
  // 2C..34 interrupt status, enable, clear
  // Unmapped offsets read as zero
  // No wait states: every access is one cycle

  digital_port_pkg::port_mode_t mode_reg; // Mode caught after reset
  logic strapTaken_reg; // Strap sampled once
  logic [2:0] portValue_reg; // Written output bits
  logic line2Dir_reg; // 1 = line 2 is an output
  logic [SW-1:0] operEvent_reg, quesEvent_reg, stdEvent_reg; // Latched events
  logic [SW-1:0] operEnable_reg, quesEnable_reg, stdEnable_reg; // Event enables
  logic [SW-1:0] operPrev_reg, quesPrev_reg, stdPrev_reg; // For rising edges
  logic shutdownPrev_reg; // Previous shutdown level
  logic tripped_reg; // Remote shutdown protection latched
  logic [IW-1:0] irqStatus_reg, irqEnable_reg; // Interrupt bits
  logic [RELAY_BITS-1:0] relayShift_reg; // Outgoing relay data
  logic [RELAY_BITS-1:0] relayRx_reg; // Readback from accessory
  logic [RELAY_BITS-1:0] relayState_reg; // Last full readback
  logic [$clog2(RELAY_BITS+1)-1:0] relayCount_reg; // Bits left
  logic [15:0] relayTimer_reg; // Bit time divider
  logic relayBusy_reg; // Frame in progress
  logic relayErr_reg; // Sticky command error

  // Named strobes
  logic wrHit, rdHit;
  logic shutdownLow, shutdownFall, relayBitTick, relayDone, relayCmdErr;
  logic operSum, quesSum, stdSum, faultActive;
  logic [SW-1:0] remoteShutdownEvent;

  // Address compare shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  assign wrHit = regWrStrobe;
  assign rdHit = regRdStrobe;

  // Line 2 doubles as the shutdown input in fault mode.
  // It is taken as already synchronous to core_clk;
  // an asynchronous source needs a synchroniser outside.
  // The analog gate keeps an external setpoint running,
  // so a chained fault cannot stop such an output.
  // Limitation: the strap is not seen until the first
  // edge after reset, so fault mode rules for one cycle.
  // Line 2 idles high through its pull-up then.
  // Shutdown acts only in fault mode and on digitally programmed output
  assign shutdownLow = (mode_reg == digital_port_pkg::MODE_FAULT_INHIBIT)
                       && !line2In && !analogProgramming;
  assign shutdownFall = shutdownLow && !shutdownPrev_reg;

  // Remote shutdown event is its own questionable bit
  always_comb begin
    remoteShutdownEvent = '0;
    remoteShutdownEvent[digital_port_pkg::QUES_SHUTDOWN_BIT] = shutdownFall;
  end

  // Summary bits only see enabled events
  assign operSum = |(operEvent_reg & operEnable_reg);
  assign quesSum = |(quesEvent_reg & quesEnable_reg);
  assign stdSum = |(stdEvent_reg & stdEnable_reg);
  assign faultActive = operSum | quesSum | stdSum;

  // Strap caught after reset release; relay strap wins over digital I/O
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= digital_port_pkg::MODE_FAULT_INHIBIT;
      strapTaken_reg <= 1'b0;
    end else if (!strapTaken_reg) begin
      strapTaken_reg <= 1'b1;
      if (strapRelayLink) begin
        mode_reg <= digital_port_pkg::MODE_RELAY_LINK;
      end else if (strapDigitalIo) begin
        mode_reg <= digital_port_pkg::MODE_DIGITAL_IO;
      end
    end
  end

  // Port value and line 2 direction; extra bits dropped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      portValue_reg <= digital_port_pkg::PORT_VALUE_RST;
      line2Dir_reg <= 1'b0;
    end else if (wrHit) begin
      if (hit(regAddr, digital_port_pkg::PORT_VALUE_OFS)) begin
        portValue_reg <= regWrData[2:0];
      end
      if (hit(regAddr, digital_port_pkg::LINE2_DIR_OFS)) begin
        line2Dir_reg <= regWrData[0];
      end
    end
  end

  // Event groups share one pattern: a condition
  // that rises sets its event bit, and the bit stays
  // until software reads that group.
  // A condition still present at the read sets the
  // bit again at once, so the fault pin cannot drop
  // before the cause is gone.
  // Trade-off: a read racing a new edge keeps the
  // bit, so no event is ever lost to a clear.
  // Event latching: set on rising or high condition, cleared by read; set wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      operEvent_reg <= '0;
      quesEvent_reg <= '0;
      stdEvent_reg <= '0;
      operPrev_reg <= '0;
      quesPrev_reg <= '0;
      stdPrev_reg <= '0;
    end else begin
      operPrev_reg <= operCondition;
      quesPrev_reg <= quesCondition;
      stdPrev_reg <= stdCondition;
      // Read clears, but a live condition or new edge keeps the bit
      operEvent_reg <= ((rdHit && hit(regAddr, digital_port_pkg::OPER_EVENT_OFS))
                        ? '0 : operEvent_reg) | (operCondition & ~operPrev_reg)
                        | operCondition;
      quesEvent_reg <= ((rdHit && hit(regAddr, digital_port_pkg::QUES_EVENT_OFS))
                        ? '0 : quesEvent_reg) | (quesCondition & ~quesPrev_reg)
                        | quesCondition | remoteShutdownEvent;
      stdEvent_reg <= ((rdHit && hit(regAddr, digital_port_pkg::STD_EVENT_OFS))
                       ? '0 : stdEvent_reg) | (stdCondition & ~stdPrev_reg)
                       | stdCondition;
    end
  end

  // Enable registers steer the fault summary
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      operEnable_reg <= digital_port_pkg::ENABLE_RST;
      quesEnable_reg <= digital_port_pkg::ENABLE_RST;
      stdEnable_reg <= digital_port_pkg::ENABLE_RST;
    end else if (wrHit) begin
      if (hit(regAddr, digital_port_pkg::OPER_ENABLE_OFS)) operEnable_reg <= regWrData[SW-1:0];
      if (hit(regAddr, digital_port_pkg::QUES_ENABLE_OFS)) quesEnable_reg <= regWrData[SW-1:0];
      if (hit(regAddr, digital_port_pkg::STD_ENABLE_OFS)) stdEnable_reg <= regWrData[SW-1:0];
    end
  end

  // Trip latch for the remote shutdown.
  // The live input wins over any clear request,
  // so a clear while the input is low is lost and
  // must be issued again after release.
  // Front panel and register clears are treated alike.
  // The previous level feeds the edge detector;
  // it resets low, which matches an idle high pin
  // and so gives no false edge after reset.
  // Protection trip; clear only honoured once the input is released
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tripped_reg <= 1'b0;
      shutdownPrev_reg <= 1'b0;
    end else begin
      shutdownPrev_reg <= shutdownLow;
      if (shutdownLow) begin
        tripped_reg <= 1'b1;
      end else if (frontPanelClear
                   || (wrHit && hit(regAddr, digital_port_pkg::PROT_CLEAR_OFS))) begin
        tripped_reg <= 1'b0;
      end
    end
  end

  // Relay link frames go out most significant bit
  // first on line 0, one bit per bit time.
  // The readback on line 2 is sampled at the end of
  // each bit time, just before the next bit goes out,
  // so the accessory has the whole bit to answer.
  // A command outside relay mode only flags an error
  // and starts nothing on the lines.
  // Busy is visible in the control register.
  // Relay link: one frame per accepted command
  assign relayCmdErr = wrHit && hit(regAddr, digital_port_pkg::RELAY_CMD_OFS)
                       && (mode_reg != digital_port_pkg::MODE_RELAY_LINK);
  assign relayBitTick = relayBusy_reg && (relayTimer_reg == 16'h0000);
  assign relayDone = relayBitTick && (relayCount_reg == 1);

  // Bit timer, shifter and readback sampler
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      relayShift_reg <= '0;
      relayRx_reg <= '0;
      relayState_reg <= '0;
      relayCount_reg <= '0;
      relayTimer_reg <= 16'h0000;
      relayBusy_reg <= 1'b0;
    end else if (!relayBusy_reg) begin
      // Commands during a frame are dropped to keep frames whole
      if (wrHit && hit(regAddr, digital_port_pkg::RELAY_CMD_OFS)
          && mode_reg == digital_port_pkg::MODE_RELAY_LINK) begin
        relayShift_reg <= regWrData[RELAY_BITS-1:0];
        relayCount_reg <= ($clog2(RELAY_BITS+1))'(RELAY_BITS);
        relayTimer_reg <= 16'(digital_port_pkg::RELAY_BIT_CYC - 1);
        relayBusy_reg <= 1'b1;
      end
    end else if (relayBitTick) begin
      relayShift_reg <= {relayShift_reg[RELAY_BITS-2:0], 1'b0};
      relayRx_reg <= {relayRx_reg[RELAY_BITS-2:0], line2In};
      relayCount_reg <= relayCount_reg - 1'b1;
      relayTimer_reg <= 16'(digital_port_pkg::RELAY_BIT_CYC - 1);
      if (relayDone) begin
        relayBusy_reg <= 1'b0;
        relayState_reg <= {relayRx_reg[RELAY_BITS-2:0], line2In};
      end
    end else begin
      relayTimer_reg <= relayTimer_reg - 16'h0001;
    end
  end

  // Sticky relay error, cleared by status read; set wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      relayErr_reg <= 1'b0;
    end else begin
      relayErr_reg <= relayCmdErr
                      | (relayErr_reg && !(rdHit
                         && hit(regAddr, digital_port_pkg::CTRL_STATUS_OFS)));
    end
  end

  // Interrupt status: write-one clear, new event wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus_reg <= '0;
      irqEnable_reg <= '0;
    end else begin
      irqStatus_reg <= (irqStatus_reg
                        & ~((wrHit && hit(regAddr, digital_port_pkg::IRQ_CLEAR_OFS))
                            ? regWrData[IW-1:0] : {IW{1'b0}}))
                       | {faultActive, relayDone, relayCmdErr, shutdownFall};
      if (wrHit && hit(regAddr, digital_port_pkg::IRQ_ENABLE_OFS)) begin
        irqEnable_reg <= regWrData[IW-1:0];
      end
    end
  end

  // Read path is registered so data come from flops.
  // The value holds until the next read strobe,
  // although the master may only rely on the cycle
  // right after its strobe.
  // Port value reads show the live line 2 level,
  // not the written bit, so an input can be polled.
  // Event reads clear in the same cycle as capture,
  // so the value returned is the one before clearing.
  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 32'h0000_0000;
    end else if (rdHit) begin
      regRdData <= 32'h0000_0000;
      unique case (regAddr)
        digital_port_pkg::PORT_VALUE_OFS: regRdData[2:0] <= {line2In, portValue_reg[1:0]};
        digital_port_pkg::LINE2_DIR_OFS: regRdData[0] <= line2Dir_reg;
        digital_port_pkg::OPER_EVENT_OFS: regRdData[SW-1:0] <= operEvent_reg;
        digital_port_pkg::OPER_ENABLE_OFS: regRdData[SW-1:0] <= operEnable_reg;
        digital_port_pkg::QUES_EVENT_OFS: regRdData[SW-1:0] <= quesEvent_reg;
        digital_port_pkg::QUES_ENABLE_OFS: regRdData[SW-1:0] <= quesEnable_reg;
        digital_port_pkg::STD_EVENT_OFS: regRdData[SW-1:0] <= stdEvent_reg;
        digital_port_pkg::STD_ENABLE_OFS: regRdData[SW-1:0] <= stdEnable_reg;
        digital_port_pkg::RELAY_CMD_OFS: regRdData[RELAY_BITS-1:0] <= relayState_reg;
        digital_port_pkg::CTRL_STATUS_OFS: regRdData[5:0] <= {relayErr_reg, relayBusy_reg,
                                                           tripped_reg, faultActive, mode_reg};
        digital_port_pkg::IRQ_STATUS_OFS: regRdData[IW-1:0] <= irqStatus_reg;
        digital_port_pkg::IRQ_ENABLE_OFS: regRdData[IW-1:0] <= irqEnable_reg;
        default: regRdData <= 32'h0000_0000;
      endcase
    end
  end

  // Output enables drive the lines low when high;
  // the data outputs stay low in every mode.
  // A written one releases a line to its pull-up,
  // which is why the port value resets to all ones.
  // Line 1 is left released in fault and relay modes.
  // Line 2 is only driven once software makes it an
  // output; until then it is a plain input.
  // Changing mode needs a reset, as the strap is static.
  // Line drivers per mode; open collector only pulls low
  always_comb begin
    line0Out = 1'b0;
    line1Out = 1'b0;
    line2Out = 1'b0;
    line0Oe = 1'b0;
    line1Oe = 1'b0;
    line2Oe = 1'b0;
    unique case (mode_reg)
      digital_port_pkg::MODE_FAULT_INHIBIT: begin
        line0Oe = faultActive;
      end
      digital_port_pkg::MODE_DIGITAL_IO: begin
        line0Oe = !portValue_reg[digital_port_pkg::VALUE_LINE0_BIT];
        line1Oe = !portValue_reg[digital_port_pkg::VALUE_LINE1_BIT];
        line2Oe = line2Dir_reg && !portValue_reg[digital_port_pkg::VALUE_LINE2_BIT];
      end
      digital_port_pkg::MODE_RELAY_LINK: begin
        line0Oe = relayBusy_reg && !relayShift_reg[RELAY_BITS-1];
      end
      default: begin
        line0Oe = 1'b0;
      end
    endcase
  end

  // Main output gate: the live input stops the output
  // in the same cycle, the latch keeps it off after.
  // Service request follows the questionable summary.
  // The interrupt is a level while any enabled bit
  // of the interrupt status stays set.
  // Status bits stay set even while masked.
  assign outputEnable = !tripped_reg && !shutdownLow;
  assign protIndicator = tripped_reg;
  assign serviceRequest = quesSum;
  assign irq = |(irqStatus_reg & irqEnable_reg);
endmodule // multimode_digital_port
`default_nettype wire

// ===== testbench/port_far_side.sv
// Far-side model: external switch, chained supply or relay box on line 2.
// Assumes line 2 has a pull-up; a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module port_far_side (
  input wire logic relayOn,
  input wire logic extLow,
  input wire logic line0Oe,
  input wire logic line2Oe,
  output logic line2Wire
);
  // Wired-AND: line2Oe pulling low wins; else the relay echo when relayOn, else extLow or the pull-up
  always_comb begin
    if (line2Oe) line2Wire = 1'b0;
    else if (relayOn) line2Wire = ~line0Oe;
    else line2Wire = ~extLow;
  end
endmodule // port_far_side
`default_nettype wire

// ===== testbench/multimode_port_monitor.sv
// Checker on the top-level pins of the multimode port.
// Assumes straps are read on the first edge after reset release.
`timescale 1ns/1ps
`default_nettype none
module multimode_port_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [31:0] regRdData,
  input wire logic strapDigitalIo,
  input wire logic strapRelayLink,
  input wire logic analogProgramming,
  input wire logic line0Oe,
  input wire logic line1Oe,
  input wire logic line2In,
  input wire logic outputEnable,
  input wire logic protIndicator,
  input wire logic serviceRequest
);
  logic modeSeen_reg, dioMode_reg, relayMode_reg, faultMode;
  logic [31:0] wrData_reg; // Write data one edge late
  // Mirror of the strap capture; relay wins over digital I/O
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeSeen_reg <= 1'b0;
      dioMode_reg <= 1'b0;
      relayMode_reg <= 1'b0;
    end else if (!modeSeen_reg) begin
      modeSeen_reg <= 1'b1;
      dioMode_reg <= strapDigitalIo & ~strapRelayLink;
      relayMode_reg <= strapRelayLink;
    end
  end
  always_ff @(posedge core_clk) wrData_reg <= regWrData;
  assign faultMode = modeSeen_reg & ~dioMode_reg & ~relayMode_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_portWrite;
    dioMode_reg && regWrStrobe && regAddr == digital_port_pkg::PORT_VALUE_OFS;
  endsequence
  sequence s_linesFollow;
    line0Oe == !wrData_reg[0] && line1Oe == !wrData_reg[1];
  endsequence
  AST_SHUT_OFF: assert property (faultMode && !analogProgramming && !line2In &&
    !$past(line2In) |-> !outputEnable) else $error("output on during shutdown");
  AST_TRIP: assert property (faultMode && !analogProgramming && $fell(line2In)
    |-> ##[1:2] protIndicator) else $error("no trip on shutdown");
  AST_HOLD: assert property (protIndicator && !line2In |=> protIndicator)
    else $error("trip cleared while shutdown held");
  AST_ANALOG: assert property (faultMode && analogProgramming && !protIndicator
    |-> outputEnable) else $error("analog output disabled");
  AST_FAULT: assert property (faultMode && serviceRequest |-> ##[0:1] line0Oe)
    else $error("fault pin idle with summary set");
  AST_DIO_WR: assert property (s_portWrite |=> s_linesFollow)
    else $error("lines do not follow port write");
  AST_DIO_RD: assert property (dioMode_reg && regRdStrobe && regAddr == 8'h00
    |=> regRdData[2] == $past(line2In)) else $error("line 2 read wrong");
  AST_RELAY_SPARE: assert property (relayMode_reg |-> !line1Oe)
    else $error("unused line driven");
  AST_UNMAPPED: assert property (regRdStrobe && regAddr == 8'h3C |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
endmodule // multimode_port_monitor
bind multimode_digital_port multimode_port_monitor i_mon (.core_clk(core_clk),
  .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
  .regRdStrobe(regRdStrobe), .regRdData(regRdData), .strapDigitalIo(strapDigitalIo),
  .strapRelayLink(strapRelayLink), .analogProgramming(analogProgramming),
  .line0Oe(line0Oe), .line1Oe(line1Oe), .line2In(line2In), .outputEnable(outputEnable),
  .protIndicator(protIndicator), .serviceRequest(serviceRequest));
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the multimode digital port.
// Assumes the far-side model resolves line 2 with its pull-up.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, rdVal;
  logic regWrStrobe = 1'b0, regRdStrobe = 1'b0, frontPanelClear = 1'b0;
  logic strapDigitalIo = 1'b0, strapRelayLink = 1'b0, analogProgramming = 1'b0;
  logic [15:0] operCondition = 16'h0, quesCondition = 16'h0, stdCondition = 16'h0;
  logic extLow = 1'b0, relayOn = 1'b0, line2Wire;
  logic line0Out, line0Oe, line1Out, line1Oe, line2Out, line2Oe;
  logic outputEnable, protIndicator, serviceRequest, irq;
  int errTotal = 0, cmpCount = 0;
  always #2.5 core_clk = ~core_clk;
  // Line 0 input is unused by the design
  multimode_digital_port i_dut (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .strapDigitalIo(strapDigitalIo), .strapRelayLink(strapRelayLink),
    .analogProgramming(analogProgramming), .operCondition(operCondition),
    .quesCondition(quesCondition), .stdCondition(stdCondition),
    .frontPanelClear(frontPanelClear), .line0In(1'b0), .line0Out(line0Out),
    .line0Oe(line0Oe), .line1Out(line1Out), .line1Oe(line1Oe), .line2In(line2Wire),
    .line2Out(line2Out), .line2Oe(line2Oe), .outputEnable(outputEnable),
    .protIndicator(protIndicator), .serviceRequest(serviceRequest), .irq(irq));
  port_far_side i_far (.relayOn(relayOn), .extLow(extLow), .line0Oe(line0Oe),
    .line2Oe(line2Oe), .line2Wire(line2Wire));
  task automatic endSim();
    if (errTotal == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Settle a given number of edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    @(negedge core_clk);
    rdVal = regRdData;
  endtask
  task automatic doReset(input logic dio, input logic rly);
    @(posedge core_clk);
    arst_n <= 1'b0;
    strapDigitalIo <= dio;
    strapRelayLink <= rly;
    relayOn <= rly;
    extLow <= 1'b0;
    analogProgramming <= 1'b0;
    cyc(12);
    arst_n <= 1'b1;
    cyc(2);
  endtask
  task automatic tFaultIn();
    doReset(1'b0, 1'b0);
    rd(digital_port_pkg::CTRL_STATUS_OFS);
    chk("mode", 32'(rdVal[1:0]), 32'h0);
    analogProgramming <= 1'b1;
    extLow <= 1'b1;
    cyc(4);
    chk("anaOe", 32'(outputEnable), 32'h1);
    doReset(1'b0, 1'b0);
    wr(digital_port_pkg::IRQ_ENABLE_OFS, 32'h1);
    extLow <= 1'b1;
    cyc(4);
    chk("oe", 32'(outputEnable), 32'h0);
    chk("prot", 32'(protIndicator), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    frontPanelClear <= 1'b1;
    cyc(1);
    frontPanelClear <= 1'b0;
    cyc(2);
    chk("protLow", 32'(protIndicator), 32'h1);
    rd(digital_port_pkg::QUES_EVENT_OFS);
    chk("riEvt", 32'(rdVal[digital_port_pkg::QUES_SHUTDOWN_BIT]), 32'h1);
    extLow <= 1'b0;
    cyc(4);
    chk("oeRel", 32'(outputEnable), 32'h0);
    wr(digital_port_pkg::IRQ_ENABLE_OFS, 32'h0);
    cyc(1);
    chk("irqMask", 32'(irq), 32'h0);
    rd(digital_port_pkg::IRQ_STATUS_OFS);
    chk("irqSt", 32'(rdVal[0]), 32'h1);
    wr(digital_port_pkg::IRQ_CLEAR_OFS, 32'h1);
    rd(digital_port_pkg::IRQ_STATUS_OFS);
    chk("irqClr", 32'(rdVal[0]), 32'h0);
    wr(digital_port_pkg::PROT_CLEAR_OFS, 32'h1);
    cyc(2);
    chk("oeClr", 32'({outputEnable, protIndicator}), 32'h2);
    wr(digital_port_pkg::RELAY_CMD_OFS, 32'h00A5);
    rd(digital_port_pkg::CTRL_STATUS_OFS);
    chk("rlyErr", 32'(rdVal[5]), 32'h1);
    rd(digital_port_pkg::IRQ_STATUS_OFS);
    chk("rlyIrq", 32'(rdVal[1]), 32'h1);
  endtask
  // Each status group in turn: oper, questionable, standard event
  task automatic tFaultOut();
    logic [7:0] ev;
    for (int i = 0; i < 3; i++) begin
      ev = digital_port_pkg::OPER_EVENT_OFS + 8'(8 * i);
      {stdCondition, quesCondition, operCondition} <= 48'h0000_0000_0008 << (16 * i);
      cyc(3);
      chk("fltOff", 32'(line0Oe), 32'h0);
      wr(ev + 8'h04, 32'h0008);
      cyc(2);
      chk("fltOn", 32'(line0Oe), 32'h1);
      chk("srq", 32'(serviceRequest), 32'(i == 1));
      {stdCondition, quesCondition, operCondition} <= 48'h0;
      cyc(2);
      chk("fltHeld", 32'(line0Oe), 32'h1);
      rd(ev);
      cyc(2);
      chk("fltClr", 32'(line0Oe), 32'h0);
      wr(ev + 8'h04, 32'h0);
    end
  endtask
  task automatic tDio();
    doReset(1'b1, 1'b0);
    rd(digital_port_pkg::CTRL_STATUS_OFS);
    chk("mode", 32'(rdVal[1:0]), 32'h1);
    wr(digital_port_pkg::PORT_VALUE_OFS, 32'hFFFF_FFFA);
    cyc(1);
    chk("lines", 32'({line2Oe, line1Oe, line0Oe}), 32'h1);
    rd(digital_port_pkg::PORT_VALUE_OFS);
    chk("val", 32'(rdVal[2:0]), 32'h6);
    extLow <= 1'b1;
    cyc(3);
    rd(digital_port_pkg::PORT_VALUE_OFS);
    chk("in2", 32'(rdVal[2:0]), 32'h2);
    chk("noTrip", 32'(protIndicator), 32'h0);
    extLow <= 1'b0;
    wr(digital_port_pkg::LINE2_DIR_OFS, 32'h1);
    cyc(1);
    chk("out2", 32'(line2Oe), 32'h1);
    wr(digital_port_pkg::PORT_VALUE_OFS, 32'h0007);
    cyc(1);
    chk("rel", 32'({line2Oe, line1Oe, line0Oe}), 32'h0);
    rd(8'h3C);
    chk("unmapped", rdVal, 32'h0000_0000);
  endtask
  task automatic tRelay();
    logic [7:0] cmd;
    cmd = 8'hA5;
    doReset(1'b0, 1'b1);
    wr(digital_port_pkg::RELAY_CMD_OFS, 32'(cmd));
    for (int b = 7; b >= 0; b--) begin
      cyc(digital_port_pkg::RELAY_BIT_CYC / 2);
      chk("send", 32'(line0Oe), 32'(!cmd[b]));
      cyc(digital_port_pkg::RELAY_BIT_CYC / 2);
    end
    for (int k = 0; k < 50; k++) begin
      rd(digital_port_pkg::CTRL_STATUS_OFS);
      if (rdVal[4] === 1'b0) break;
    end
    chk("busy", 32'(rdVal[4]), 32'h0);
    rd(digital_port_pkg::RELAY_CMD_OFS);
    chk("back", 32'(rdVal[7:0]), 32'(cmd));
  endtask
  // Guard against a hang; whole run is about 16k cycles
  initial begin
    #300_000;
    errTotal++;
    endSim();
  end
  initial begin
    tFaultIn();
    tFaultOut();
    tDio();
    tRelay();
    endSim();
  end
endmodule // testbench
`default_nettype wire
